// file: verif/lfcd_top_bench.sv
// testbench: self-checking bench for the loop filter coefficient decode stage
`timescale 1ns/100ps
module lfcd_top_bench;
  // ****************************************************************
  // signals, model and case table
  // ****************************************************************
  typedef struct packed {
    logic signed [23:0] x;
    logic [15:0]        am;
    logic [15:0]        ax;
    logic [16:0]        bm;
    logic [4:0]         bx;
    logic [16:0]        gm;
    logic [4:0]         gx;
    logic [14:0]        dm;
    logic [4:0]         dx;
  } lfcd_row_t;
  localparam lfcd_row_t RST_M = '{24'h0, 16'h1, 16'h0, 17'h1, 5'h0, 17'h1, 5'h0, 15'h1, 5'h0};
  // fields as software leaves them: scaled by the clock constant, cut to field widths,
  // gain kept in front first
  lfcd_row_t rows [5] = '{
    '{24'h123456, 16'hD0A8, 16'h0006, 17'h1250B, 5'h0D, 17'h13ABB, 5'h0D, 15'h420A, 5'h08},
    '{24'h800000, 16'hFFFF, 16'hF700, 17'h1FFFF, 5'h00, 17'h00001, 5'h1F, 15'h7FFF, 5'h00},
    '{24'h7FFFFF, 16'h0001, 16'h353F, 17'h00100, 5'h1F, 17'h0FFFF, 5'h01, 15'h0001, 5'h1F},
    '{24'hFFFFFF, 16'h8000, 16'h1700, 17'h10000, 5'h02, 17'h00003, 5'h00, 15'h4000, 5'h03},
    '{24'hFFFC00, 16'h1234, 16'h0014, 17'h0ABCD, 5'h04, 17'h1FFFF, 5'h10, 15'h2222, 5'h0A}};
  logic               ref_clk;
  logic               rst_b;
  logic [3:0]         addr;
  logic [31:0]        wdata;
  logic               wr;
  logic               rd;
  logic [31:0]        rdata;
  logic signed [23:0] sample_in;
  logic               sample_valid;
  logic signed [31:0] alpha_out;
  logic signed [31:0] beta_out;
  logic signed [31:0] gamma_out;
  logic signed [31:0] delta_out;
  logic               out_valid;
  logic [20:0]        fb_div_int;
  logic [9:0]         fb_div_num;
  logic [9:0]         fb_div_den;
  lfcd_row_t          m;
  logic [19:0]        s;
  logic [9:0]         u;
  logic [9:0]         v;
  logic [31:0]        e_nxt [4];
  logic [31:0]        cur [4];
  logic [31:0]        rd_exp;
  logic [31:0]        pend_exp;
  logic               pend;
  logic               sv_q;
  int                 err_count;
  int                 tests_run;
  int                 cyc;

  lfcd_top i_lfcd_top (
    .REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SAMPLE_IN(sample_in), .SAMPLE_VALID(sample_valid),
    .ALPHA_OUT(alpha_out), .BETA_OUT(beta_out), .GAMMA_OUT(gamma_out),
    .DELTA_OUT(delta_out), .OUT_VALID(out_valid), .FB_DIV_INT(fb_div_int),
    .FB_DIV_NUM(fb_div_num), .FB_DIV_DEN(fb_div_den));

  always #50 ref_clk = ~ref_clk;

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_f(input logic [20:0] got, input logic [20:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_f

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // bus and sample drivers
  // ****************************************************************
  function automatic logic [31:0] regw(input int a);
    case (a)
      0: return {16'h0, m.am};
      1: return {16'h0, m.ax};
      2: return {3'h0, m.bx, 7'h0, m.bm};
      3: return {3'h0, m.gx, 7'h0, m.gm};
      4: return {3'h0, m.dx, 9'h0, m.dm};
      5: return {12'h0, s};
      6: return {6'h0, v, 6'h0, u};
      7: return {11'h0, 21'(s) + 21'h1};
      default: return 32'h0;
    endcase
  endfunction : regw

  // the model follows the write only once the edge has taken it
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge ref_clk);
    case (a)
      4'h0: m.am = (d[15:0] == 16'h0) ? 16'h1 : d[15:0];
      4'h1: m.ax = d[15:0] & 16'hF73F;
      4'h2: {m.bx, m.bm} = {d[28:24], (d[16:0] == 17'h0) ? 17'h1 : d[16:0]};
      4'h3: {m.gx, m.gm} = {d[28:24], (d[16:0] == 17'h0) ? 17'h1 : d[16:0]};
      4'h4: {m.dx, m.dm} = {d[28:24], (d[14:0] == 15'h0) ? 15'h1 : d[14:0]};
      4'h5: s = d[19:0];
      4'h6: {v, u} = {d[25:16], d[9:0]};
      default: ;
    endcase
  endtask : put

  task automatic get(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    rd_exp <= e;
    @(posedge ref_clk);
  endtask : get

  task automatic get_all;
    for (int a = 0; a < 16; a++) get(4'(a), regw(a));
  endtask : get_all

  task automatic idle;
    wr <= 1'b0;
    rd <= 1'b0;
    sample_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : idle

  task automatic smp(input logic signed [23:0] x);
    longint p;
    int     g;
    p = longint'(x) * longint'(m.am);
    g = (m.ax[10:8] == 3'h7) ? 7 + m.ax[15:12] : m.ax[10:8];
    e_nxt[0] <= 32'((p <<< g) >>> (16 + m.ax[5:0]));
    e_nxt[1] <= 32'(-((longint'(x) * longint'(m.bm)) >>> (17 + m.bx)));
    e_nxt[2] <= 32'(-((longint'(x) * longint'(m.gm)) >>> (17 + m.gx)));
    e_nxt[3] <= 32'((longint'(x) * longint'(m.dm)) >>> (15 + m.dx));
    wr <= 1'b0;
    rd <= 1'b0;
    sample_in <= x;
    sample_valid <= 1'b1;
    @(posedge ref_clk);
  endtask : smp

  task automatic fb_chk;
    @(negedge ref_clk);
    chk_f(fb_div_int, 21'(s) + 21'h1);
    chk_f(21'(fb_div_num), 21'(u));
    chk_f(21'(fb_div_den), 21'(v));
    @(posedge ref_clk);
  endtask : fb_chk

  // ****************************************************************
  // monitor: read data one cycle after the strobe, results one after the sample
  // ****************************************************************
  // the run needs about 220 cycles; over ten times that means a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  always @(posedge ref_clk) begin
    if (rst_b) begin
      chk_w(rdata, pend ? pend_exp : 32'h0);
      chk_f(21'(out_valid), 21'(sv_q));
      chk_w(alpha_out, cur[0]);
      chk_w(beta_out, cur[1]);
      chk_w(gamma_out, cur[2]);
      chk_w(delta_out, cur[3]);
    end
    pend <= rd & rst_b;
    pend_exp <= rd_exp;
    sv_q <= sample_valid & rst_b;
    if (!rst_b) begin
      cur <= '{default: 32'h0};
    end else if (sample_valid) begin
      cur <= e_nxt;
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {ref_clk, rst_b, wr, rd, sample_valid, pend, sv_q} = '0;
    {addr, wdata, sample_in, rd_exp, pend_exp, s, u, v} = '0;
    {err_count, tests_run, cyc} = '0;
    m = RST_M;
    e_nxt = '{default: 32'h0};
    cur = '{default: 32'h0};
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    get_all();
    idle();
    fb_chk();
    foreach (rows[i]) begin
      put(4'h0, {16'h0, rows[i].am});
      put(4'h1, {16'h0, rows[i].ax});
      put(4'h2, {3'h0, rows[i].bx, 7'h0, rows[i].bm});
      put(4'h3, {3'h0, rows[i].gx, 7'h0, rows[i].gm});
      put(4'h4, {3'h0, rows[i].dx, 9'h0, rows[i].dm});
      get_all();
      smp(rows[i].x);
      smp(~rows[i].x);
      idle();
      idle();
    end
    // zero mantissas are lifted to one; outputs must hold while coefficients change
    put(4'h0, 32'h0);
    put(4'h2, 32'h1F00_0000);
    put(4'h3, 32'h0);
    put(4'h4, 32'h0500_0000);
    idle();
    get_all();
    smp(24'h654321);
    idle();
    // divider at its top value, then writes to read-only and unmapped places
    put(4'h5, 32'h000F_FFFF);
    put(4'h6, {6'h0, 10'h155, 6'h0, 10'h3FF});
    put(4'h7, 32'h0);
    put(4'h8, 32'hFFFF_FFFF);
    put(4'hF, 32'hFFFF_FFFF);
    idle();
    fb_chk();
    get_all();
    idle();
    // reset in mid-run clears everything back to its start value
    rst_b <= 1'b0;
    @(negedge ref_clk);
    chk_w(alpha_out | beta_out | gamma_out | delta_out | rdata, 32'h0);
    chk_f(fb_div_int, 21'h1);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    m = RST_M;
    {s, u, v} = '0;
    get_all();
    smp(24'h000ABC);
    smp(24'h000001);
    smp(24'h020000);
    smp(24'h008000);
    idle();
    idle();
    results();
  end
endmodule : lfcd_top_bench

// file: verilog/lfcd_pkg.sv
// package: register map, field layout and widths of the loop filter coefficient decode stage
package lfcd_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int SMP_W    = 24;
  localparam int OUT_W    = 32;
  localparam int PROD_W   = 64;
  localparam int AM_W     = 16;
  localparam int AS_W     = 6;
  localparam int FE_W     = 3;
  localparam int BE_W     = 4;
  localparam int BG_M_W   = 17;
  localparam int D_M_W    = 15;
  localparam int EXP_W    = 5;
  localparam int S_W      = 20;
  localparam int UV_W     = 10;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_ALPHA_MANT = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ALPHA_EXP  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_BETA       = 4'h2;
  localparam logic [ADDR_W-1:0] REG_GAMMA      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DELTA      = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FB_INT     = 4'h5;
  localparam logic [ADDR_W-1:0] REG_FB_FRAC    = 4'h6;
  localparam logic [ADDR_W-1:0] REG_FB_RATIO   = 4'h7;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AS_LSB   = 0;
  localparam int FE_LSB   = 8;
  localparam int BE_LSB   = 12;
  localparam int EXP_LSB  = 24;
  localparam int V_LSB    = 16;

  // ****************************************************************
  // limits, scale offsets and reset values
  // ****************************************************************
  localparam logic [FE_W-1:0]   FE_MAX     = 3'h7;
  localparam logic [BE_W-1:0]   BE_MAX     = 4'hF;
  localparam logic [6:0]        ALPHA_BASE = 7'h10;
  localparam logic [5:0]        BG_BASE    = 6'h11;
  localparam logic [5:0]        D_BASE     = 6'h0F;
  localparam logic [BG_M_W-1:0] MANT_MIN   = 17'h00001;
  localparam logic [S_W:0]      DIV_ONE    = 21'h000001;
  localparam logic [DATA_W-1:0] RD_ZERO    = 32'h0000_0000;

endpackage : lfcd_pkg

// file: verilog/lfcd_top.sv
// module: loop filter coefficient decode, register file and fixed-point coefficient multiply
`timescale 1ns/100ps
module lfcd_top (
  // clock and reset
  input  wire logic                               REF_CLK,
  input  wire logic                               RST_B,
  // register port
  input  wire logic [lfcd_pkg::ADDR_W-1:0]        ADDR,
  input  wire logic [lfcd_pkg::DATA_W-1:0]        WDATA,
  input  wire logic                               WR,
  input  wire logic                               RD,
  output logic      [lfcd_pkg::DATA_W-1:0]        RDATA,
  // filter samples in
  input  wire logic signed [lfcd_pkg::SMP_W-1:0]  SAMPLE_IN,
  input  wire logic                               SAMPLE_VALID,
  // weighted samples out
  output logic signed [lfcd_pkg::OUT_W-1:0]       ALPHA_OUT,
  output logic signed [lfcd_pkg::OUT_W-1:0]       BETA_OUT,
  output logic signed [lfcd_pkg::OUT_W-1:0]       GAMMA_OUT,
  output logic signed [lfcd_pkg::OUT_W-1:0]       DELTA_OUT,
  output logic                                    OUT_VALID,
  // feedback divider, decoded
  output logic      [lfcd_pkg::S_W:0]             FB_DIV_INT,
  output logic      [lfcd_pkg::UV_W-1:0]          FB_DIV_NUM,
  output logic      [lfcd_pkg::UV_W-1:0]          FB_DIV_DEN
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one shared multiply-and-shift; exponents never need a float unit
  function automatic logic signed [lfcd_pkg::PROD_W-1:0] coef_apply(
    input logic signed [lfcd_pkg::SMP_W-1:0]  x,
    input logic        [lfcd_pkg::BG_M_W-1:0] m,
    input logic        [4:0]                  up,
    input logic        [6:0]                  down
  );
    logic signed [lfcd_pkg::PROD_W-1:0] p;
    p = lfcd_pkg::PROD_W'(x) * $signed({47'h0, m});
    p = p <<< up;
    p = p >>> down;
    return p;
  endfunction : coef_apply

  // zero mantissa would kill the loop, so it is held at one
  function automatic logic [lfcd_pkg::BG_M_W-1:0] mant_clamp(
    input logic [lfcd_pkg::BG_M_W-1:0] m
  );
    return (m == '0) ? lfcd_pkg::MANT_MIN : m;
  endfunction : mant_clamp

  // ****************************************************************
  // coefficient and divider registers
  // ****************************************************************
  logic [lfcd_pkg::AM_W-1:0]   a_mant_q,  a_mant_d;
  logic [lfcd_pkg::AS_W-1:0]   a_shift_q, a_shift_d;
  logic [lfcd_pkg::FE_W-1:0]   fe_gain_q, fe_gain_d;
  logic [lfcd_pkg::BE_W-1:0]   be_gain_q, be_gain_d;
  logic [lfcd_pkg::BG_M_W-1:0] b_mant_q,  b_mant_d;
  logic [lfcd_pkg::EXP_W-1:0]  b_exp_q,   b_exp_d;
  logic [lfcd_pkg::BG_M_W-1:0] g_mant_q,  g_mant_d;
  logic [lfcd_pkg::EXP_W-1:0]  g_exp_q,   g_exp_d;
  logic [lfcd_pkg::D_M_W-1:0]  d_mant_q,  d_mant_d;
  logic [lfcd_pkg::EXP_W-1:0]  d_exp_q,   d_exp_d;
  logic [lfcd_pkg::S_W-1:0]    s_q,       s_d;
  logic [lfcd_pkg::UV_W-1:0]   u_q,       u_d;
  logic [lfcd_pkg::UV_W-1:0]   v_q,       v_d;
  logic [lfcd_pkg::DATA_W-1:0] rdata_q,   rdata_d;
  logic [lfcd_pkg::BE_W-1:0]   be_eff;
  logic [lfcd_pkg::S_W:0]      div_q,     div_d;
  logic [lfcd_pkg::BE_W-1:0]   be_wr;

  // back gain only counts once the front stage is at its ceiling
  assign be_eff  = (fe_gain_q == lfcd_pkg::FE_MAX) ? be_gain_q : '0;
  // ratio is registered beside the divider so both change on one edge
  assign div_d   = {1'b0, s_d} + lfcd_pkg::DIV_ONE;
  assign be_wr   = WDATA[lfcd_pkg::BE_LSB +: lfcd_pkg::BE_W];

  always_comb begin
    a_mant_d  = a_mant_q;
    a_shift_d = a_shift_q;
    fe_gain_d = fe_gain_q;
    be_gain_d = be_gain_q;
    b_mant_d  = b_mant_q;
    b_exp_d   = b_exp_q;
    g_mant_d  = g_mant_q;
    g_exp_d   = g_exp_q;
    d_mant_d  = d_mant_q;
    d_exp_d   = d_exp_q;
    s_d       = s_q;
    u_d       = u_q;
    v_d       = v_q;
    rdata_d   = lfcd_pkg::RD_ZERO;
    if (WR) begin
      unique case (ADDR)
        lfcd_pkg::REG_ALPHA_MANT: begin
          a_mant_d = lfcd_pkg::AM_W'(mant_clamp({1'b0, WDATA[lfcd_pkg::AM_W-1:0]}));
        end
        lfcd_pkg::REG_ALPHA_EXP: begin
          a_shift_d = WDATA[lfcd_pkg::AS_LSB +: lfcd_pkg::AS_W];
          fe_gain_d = WDATA[lfcd_pkg::FE_LSB +: lfcd_pkg::FE_W];
          // total gain tops out at 22, so back gain stops at 15
          be_gain_d = (be_wr > lfcd_pkg::BE_MAX) ? lfcd_pkg::BE_MAX : be_wr;
        end
        lfcd_pkg::REG_BETA: begin
          b_mant_d = mant_clamp(WDATA[lfcd_pkg::BG_M_W-1:0]);
          b_exp_d  = WDATA[lfcd_pkg::EXP_LSB +: lfcd_pkg::EXP_W];
        end
        lfcd_pkg::REG_GAMMA: begin
          g_mant_d = mant_clamp(WDATA[lfcd_pkg::BG_M_W-1:0]);
          g_exp_d  = WDATA[lfcd_pkg::EXP_LSB +: lfcd_pkg::EXP_W];
        end
        lfcd_pkg::REG_DELTA: begin
          d_mant_d = lfcd_pkg::D_M_W'(mant_clamp({2'b00, WDATA[lfcd_pkg::D_M_W-1:0]}));
          d_exp_d  = WDATA[lfcd_pkg::EXP_LSB +: lfcd_pkg::EXP_W];
        end
        lfcd_pkg::REG_FB_INT: begin
          s_d = WDATA[lfcd_pkg::S_W-1:0];
        end
        lfcd_pkg::REG_FB_FRAC: begin
          u_d = WDATA[lfcd_pkg::UV_W-1:0];
          v_d = WDATA[lfcd_pkg::V_LSB +: lfcd_pkg::UV_W];
        end
        default: begin
        end
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        lfcd_pkg::REG_ALPHA_MANT: rdata_d = {16'h0000, a_mant_q};
        lfcd_pkg::REG_ALPHA_EXP:  rdata_d = {16'h0000, be_gain_q, 1'b0, fe_gain_q, 2'b00,
                                             a_shift_q};
        lfcd_pkg::REG_BETA:       rdata_d = {3'h0, b_exp_q, 7'h00, b_mant_q};
        lfcd_pkg::REG_GAMMA:      rdata_d = {3'h0, g_exp_q, 7'h00, g_mant_q};
        lfcd_pkg::REG_DELTA:      rdata_d = {3'h0, d_exp_q, 9'h000, d_mant_q};
        lfcd_pkg::REG_FB_INT:     rdata_d = {12'h000, s_q};
        lfcd_pkg::REG_FB_FRAC:    rdata_d = {6'h00, v_q, 6'h00, u_q};
        lfcd_pkg::REG_FB_RATIO:   rdata_d = {11'h000, div_q};
        default:                  rdata_d = lfcd_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      a_mant_q  <= lfcd_pkg::AM_W'(lfcd_pkg::MANT_MIN);
      a_shift_q <= '0;
      fe_gain_q <= '0;
      be_gain_q <= '0;
      b_mant_q  <= lfcd_pkg::MANT_MIN;
      b_exp_q   <= '0;
      g_mant_q  <= lfcd_pkg::MANT_MIN;
      g_exp_q   <= '0;
      d_mant_q  <= lfcd_pkg::D_M_W'(lfcd_pkg::MANT_MIN);
      d_exp_q   <= '0;
      s_q       <= '0;
      u_q       <= '0;
      v_q       <= '0;
      rdata_q   <= '0;
      div_q     <= lfcd_pkg::DIV_ONE;
    end else begin
      a_mant_q  <= a_mant_d;
      a_shift_q <= a_shift_d;
      fe_gain_q <= fe_gain_d;
      be_gain_q <= be_gain_d;
      b_mant_q  <= b_mant_d;
      b_exp_q   <= b_exp_d;
      g_mant_q  <= g_mant_d;
      g_exp_q   <= g_exp_d;
      d_mant_q  <= d_mant_d;
      d_exp_q   <= d_exp_d;
      s_q       <= s_d;
      u_q       <= u_d;
      v_q       <= v_d;
      rdata_q   <= rdata_d;
      div_q     <= div_d;
    end
  end

  assign RDATA      = rdata_q;
  assign FB_DIV_INT = div_q;
  assign FB_DIV_NUM = u_q;
  assign FB_DIV_DEN = v_q;

  // ****************************************************************
  // coefficient datapath
  // ****************************************************************
  logic signed [lfcd_pkg::OUT_W-1:0] alpha_q, alpha_d, beta_q, beta_d;
  logic signed [lfcd_pkg::OUT_W-1:0] gamma_q, gamma_d, delta_q, delta_d;
  logic                              valid_q, valid_d;
  logic [4:0]                        a_up;
  logic [6:0]                        a_down;

  assign a_up   = 5'({2'b00, fe_gain_q} + {1'b0, be_eff});
  assign a_down = lfcd_pkg::ALPHA_BASE + {1'b0, a_shift_q};

  // results are cut to the output width; a sane loop keeps them in range
  always_comb begin
    valid_d = SAMPLE_VALID;
    alpha_d = alpha_q;
    beta_d  = beta_q;
    gamma_d = gamma_q;
    delta_d = delta_q;
    if (SAMPLE_VALID) begin
      alpha_d = lfcd_pkg::OUT_W'(coef_apply(SAMPLE_IN, {1'b0, a_mant_q}, a_up,
                                            a_down));
      beta_d  = lfcd_pkg::OUT_W'(-coef_apply(SAMPLE_IN, b_mant_q, 5'h00,
                                  {1'b0, lfcd_pkg::BG_BASE} + {2'b00, b_exp_q}));
      gamma_d = lfcd_pkg::OUT_W'(-coef_apply(SAMPLE_IN, g_mant_q, 5'h00,
                                  {1'b0, lfcd_pkg::BG_BASE} + {2'b00, g_exp_q}));
      delta_d = lfcd_pkg::OUT_W'(coef_apply(SAMPLE_IN, {2'b00, d_mant_q}, 5'h00,
                                  {1'b0, lfcd_pkg::D_BASE} + {2'b00, d_exp_q}));
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      valid_q <= 1'b0;
      alpha_q <= '0;
      beta_q  <= '0;
      gamma_q <= '0;
      delta_q <= '0;
    end else begin
      valid_q <= valid_d;
      alpha_q <= alpha_d;
      beta_q  <= beta_d;
      gamma_q <= gamma_d;
      delta_q <= delta_d;
    end
  end

  assign OUT_VALID = valid_q;
  assign ALPHA_OUT = alpha_q;
  assign BETA_OUT  = beta_q;
  assign GAMMA_OUT = gamma_q;
  assign DELTA_OUT = delta_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_pos_sample;
    SAMPLE_VALID && (SAMPLE_IN > 0);
  endsequence
  sequence s_out_nonpos;
    OUT_VALID && (BETA_OUT <= 0) && (GAMMA_OUT <= 0);
  endsequence

  property p_neg_bg;
    @(posedge REF_CLK) disable iff (!RST_B) s_pos_sample |=> s_out_nonpos;
  endproperty
  a_neg_bg: assert property (p_neg_bg) else $error("beta or gamma not negated");

  property p_shift_wr;
    @(posedge REF_CLK) disable iff (!RST_B)
      (WR && ADDR == lfcd_pkg::REG_ALPHA_EXP) |=>
        (a_shift_q == $past(WDATA[5:0])) && (a_down == 7'h10 + $past(WDATA[5:0]));
  endproperty
  a_shift_wr: assert property (p_shift_wr) else $error("alpha shift not taken");

  property p_gain_split;
    @(posedge REF_CLK) disable iff (!RST_B)
      (WR && ADDR == lfcd_pkg::REG_ALPHA_EXP) |=>
        (a_up == (($past(WDATA[10:8]) == 3'h7) ? 5'h07 + {1'b0, $past(WDATA[15:12])}
                                                 : {2'b00, $past(WDATA[10:8])}));
  endproperty
  a_gain_split: assert property (p_gain_split) else $error("gain split wrong");

  property p_alpha_val;
    @(posedge REF_CLK) disable iff (!RST_B)
      (SAMPLE_VALID && SAMPLE_IN == 24'h000001 && a_shift_q == 6'h00 && a_up == 5'h00)
        |=> ALPHA_OUT == 32'h0000_0000;
  endproperty
  a_alpha_val: assert property (p_alpha_val) else $error("alpha scale wrong");

  property p_beta_mant;
    @(posedge REF_CLK) disable iff (!RST_B)
      (WR && ADDR == lfcd_pkg::REG_BETA) |=> (b_mant_q != 17'h00000) ##1 (b_mant_q != 17'h00000);
  endproperty
  a_beta_mant: assert property (p_beta_mant) else $error("beta mantissa zero");

  property p_gamma_val;
    @(posedge REF_CLK) disable iff (!RST_B)
      (SAMPLE_VALID && SAMPLE_IN == 24'h020000 && g_exp_q == 5'h00)
        |=> GAMMA_OUT == -$signed({15'h0000, $past(g_mant_q)});
  endproperty
  a_gamma_val: assert property (p_gamma_val) else $error("gamma scale wrong");

  property p_delta_val;
    @(posedge REF_CLK) disable iff (!RST_B)
      (SAMPLE_VALID && SAMPLE_IN == 24'h008000 && d_exp_q == 5'h00)
        |=> DELTA_OUT == $signed({17'h00000, $past(d_mant_q)});
  endproperty
  a_delta_val: assert property (p_delta_val) else $error("delta scale wrong");

  property p_ratio;
    @(posedge REF_CLK) disable iff (!RST_B)
      (RD && ADDR == lfcd_pkg::REG_FB_RATIO && !WR) |=>
        RDATA == {11'h000, {1'b0, $past(s_q)} + 21'h000001};
  endproperty
  a_ratio: assert property (p_ratio) else $error("divide ratio readback wrong");

  property p_pipe;
    @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_VALID ##1 !SAMPLE_VALID |-> OUT_VALID ##1 !OUT_VALID;
  endproperty
  a_pipe: assert property (p_pipe) else $error("output valid misaligned");

endmodule : lfcd_top
